// ### rlar_top.v
// Operation
// - reference lost when analog reference drops 90% or more within 400 ms
// - with continue-on-loss, keep running at 80% of pre-loss speed
// - terminal selected with code C asserts while reference is lost
// - loss action 0 follows reference and stops, 1 continues reduced speed
// - loss speed is stored speed times ratio, 0.0 to 100.0%, default 80.0
// - eligible fault runs self-diagnosis, restart only if it passes
// - only listed faults restart; any other fault trips without restart
// - undervoltage eligible only when ride-through selector is 1 or 2
// - attempt limit 0 to 10, default 0; restart begins speed search at run freq
// - terminal selected with code 1E signals auto-restart
// - fault contact during restart: 0 inactive, 1 active
// - attempt counter cleared after 10 minutes fault-free after restart
// - controller confirms trip and applies error reset; counter then cleared
// - attempt counter starts at zero after power cycle
`include "rlar_regs.vh"
module rlar_top #(
	parameter [31:0] WIN_CYC = `RLAR_WIN_CYC, // loss window in cycles
	parameter [39:0] OK_CYC = `RLAR_OK_CYC, // fault-free time in cycles
	parameter [7:0] DIAG_CYC = `RLAR_DIAG_CYC // self-diagnosis length
) (
	input wire core_clk_i, // 250 MHz clock
	input wire srst_i, // sync reset, also power-on
	input wire psel_i, // apb select
	input wire penable_i, // apb enable
	input wire pwrite_i, // apb direction
	input wire [11:0] paddr_i, // apb address
	input wire [31:0] pwdata_i, // apb write data
	output wire [31:0] prdata_o, // apb read data
	output wire pready_o, // apb ready
	output wire pslverr_o, // apb error
	input wire run_i, // run command (pin)
	input wire [15:0] ref_i, // analog reference sample
	input wire [`RLAR_FLT_W-1:0] fault_i, // fault levels (pins)
	input wire diag_err_i, // self-diagnosis error (pin)
	input wire err_reset_i, // external error reset (pin)
	output reg [15:0] speed_cmd_o, // speed command
	output reg search_o, // speed search request
	output reg [2:0] term_o, // multi-function contacts
	output reg fault_contact_o, // fault contact
	output wire irq_o // interrupt level
);
	localparam ST_RUN = 3'd0;
	localparam ST_DIAG = 3'd1;
	localparam ST_RST = 3'd2;
	localparam ST_TRIP = 3'd3;
	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	reg run_s1_q, run_q, diag_s1_q, diag_q, erst_s1_q, erst_q, erst_d_q;
	reg [`RLAR_FLT_W-1:0] flt_s1_q, flt_q;
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			run_s1_q <= 1'b0;
			run_q <= 1'b0;
			diag_s1_q <= 1'b0;
			diag_q <= 1'b0;
			erst_s1_q <= 1'b0;
			erst_q <= 1'b0;
			erst_d_q <= 1'b0;
			flt_s1_q <= {`RLAR_FLT_W{1'b0}};
			flt_q <= {`RLAR_FLT_W{1'b0}};
		end else begin
			run_s1_q <= run_i;
			run_q <= run_s1_q;
			diag_s1_q <= diag_err_i;
			diag_q <= diag_s1_q;
			erst_s1_q <= err_reset_i;
			erst_q <= erst_s1_q;
			erst_d_q <= erst_q;
			flt_s1_q <= fault_i;
			flt_q <= flt_s1_q;
		end
	end
	wire erst_pulse = erst_q & ~erst_d_q;
	////////////////////////////////////////////////////////////////////////
	// registers
	reg [31:0] cfg_q, cmd_q;
	reg [2:0] irq_stat_q, irq_en_q;
	reg [3:0] cnt_q;
	reg [2:0] st_q;
	wire acc = psel_i & penable_i;
	wire wr = acc & pwrite_i;
	wire [3:0] lim = cfg_q[`RLAR_CFG_LIM_LSB+3:`RLAR_CFG_LIM_LSB];
	wire [9:0] ratio = cfg_q[`RLAR_CFG_RATIO_LSB+9:`RLAR_CFG_RATIO_LSB];
	wire [1:0] plr = cfg_q[`RLAR_CFG_PLR_LSB+1:`RLAR_CFG_PLR_LSB];
	// out-of-range limit and ratio values are clamped, so the block never exceeds spec
	wire [3:0] wlim = pwdata_i[`RLAR_CFG_LIM_LSB+3:`RLAR_CFG_LIM_LSB];
	wire [9:0] wrat = pwdata_i[`RLAR_CFG_RATIO_LSB+9:`RLAR_CFG_RATIO_LSB];
	wire [3:0] lim_c = (wlim > `RLAR_LIM_MAX) ? `RLAR_LIM_MAX : wlim;
	wire [9:0] rat_c = (wrat > `RLAR_RATIO_MAX) ? `RLAR_RATIO_MAX : wrat;
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			cfg_q <= {6'h1e, 6'h0c, 2'h0, `RLAR_RATIO_RST, `RLAR_LIM_RST, 4'h0};
			cmd_q <= 32'h0;
			irq_en_q <= 3'h0;
		end else if (wr) begin
			if (paddr_i == `RLAR_CFG_OFF)
				cfg_q <= {pwdata_i[31:18], rat_c, lim_c, pwdata_i[3:0]};
			if (paddr_i == `RLAR_IRQ_EN_OFF)
				irq_en_q <= pwdata_i[2:0];
			if (paddr_i == `RLAR_CMD_OFF)
				cmd_q <= pwdata_i;
		end
	end
	function known;
		input [11:0] a;
		begin
			known = (a[11:5] == 7'h0) && (a[1:0] == 2'b00);
		end
	endfunction
	reg [31:0] rd;
	wire lost;
	always @* begin
		case (paddr_i)
		`RLAR_CFG_OFF: rd = cfg_q;
		`RLAR_REF_OFF: rd = {16'h0, ref_i};
		`RLAR_FLT_OFF: rd = {16'h0, flt_q};
		`RLAR_STAT_OFF: rd = {20'h0, cnt_q, 1'b0, st_q, 3'h0, lost};
		`RLAR_IRQ_STAT_OFF: rd = {29'h0, irq_stat_q};
		`RLAR_IRQ_EN_OFF: rd = {29'h0, irq_en_q};
		`RLAR_CMD_OFF: rd = cmd_q;
		default: rd = 32'h0;
		endcase
	end
	assign prdata_o = (acc && !pwrite_i) ? rd : 32'h0;
	assign pready_o = 1'b1; // zero wait states
	assign pslverr_o = acc & ~known(paddr_i);
	////////////////////////////////////////////////////////////////////////
	// reference loss
	rlar_ref_mon #(
		.WIN_CYC(WIN_CYC)
	) u_mon (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.ref_i(ref_i),
		.run_i(run_q),
		.lost_o(lost)
	);
	reg [15:0] held_q, ref_d_q;
	wire [25:0] prod = held_q * ratio;
	wire [25:0] quo = prod / 26'd1000;
	wire [15:0] red_spd = quo[15:0];
	// held speed lags one cycle, so the collapsed sample that trips the loss never lands in it
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			ref_d_q <= 16'h0;
			held_q <= 16'h0;
		end else begin
			ref_d_q <= ref_i;
			if (!lost)
				held_q <= ref_d_q;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// fault classification and restart sequencer
	wire [`RLAR_FLT_W-1:0] elig_mask = `RLAR_ELIG_MASK &
		~((plr == 2'd1 || plr == 2'd2) ? 16'h0 : (16'h1 << `RLAR_F_UV));
	wire any_f = |flt_q;
	wire elig = any_f && ((flt_q & ~elig_mask) == 16'h0);
	reg [7:0] dcnt_q;
	reg [39:0] ok_q;
	reg ok_arm_q;
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			st_q <= ST_RUN;
			cnt_q <= 4'h0;
			dcnt_q <= 8'h0;
			ok_q <= 40'h0;
			ok_arm_q <= 1'b0;
		end else begin
			case (st_q)
			ST_RUN: begin
				if (run_q && any_f) begin
					ok_arm_q <= 1'b0;
					ok_q <= 40'h0;
					if (!elig)
						st_q <= ST_TRIP;
					else if (cnt_q >= lim)
						st_q <= ST_TRIP;
					else begin
						st_q <= ST_DIAG;
						dcnt_q <= 8'h0;
					end
				end else if (ok_arm_q) begin
					// apart from the error reset that clears a trip, the counter resets only after a full quiet period
					if (ok_q >= OK_CYC - 40'h1) begin
						cnt_q <= 4'h0;
						ok_arm_q <= 1'b0;
					end else
						ok_q <= ok_q + 40'h1;
				end
			end
			ST_DIAG: begin
				dcnt_q <= dcnt_q + 8'h1;
				if (diag_q)
					st_q <= ST_TRIP;
				else if (dcnt_q >= DIAG_CYC - 8'h1 && !any_f)
					st_q <= ST_RST;
			end
			ST_RST: begin
				cnt_q <= cnt_q + 4'h1;
				ok_arm_q <= 1'b1;
				ok_q <= 40'h0;
				st_q <= ST_RUN;
			end
			ST_TRIP: begin
				if (erst_pulse && !any_f) begin
					cnt_q <= 4'h0;
					st_q <= ST_RUN;
				end
			end
			default: st_q <= ST_RUN;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// outputs
	wire act = cfg_q[`RLAR_CFG_ACT_BIT];
	wire restarting = (st_q == ST_DIAG) || (st_q == ST_RST);
	wire [2:0] ev = {st_q == ST_TRIP, st_q == ST_RST, lost};
	function term_fn;
		input [5:0] code;
		input l, r, t;
		begin
			term_fn = (code == `RLAR_FN_REF_LOST && l) ||
				(code == `RLAR_FN_RESTART && r) ||
				(code == `RLAR_FN_FAULT && t);
		end
	endfunction
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_term
			// terminals 0 and 1 use cfg code fields, 2 comes from command register
			wire [5:0] code = (g == 0) ? cfg_q[`RLAR_CFG_T0_LSB+5:`RLAR_CFG_T0_LSB] :
				(g == 1) ? cfg_q[`RLAR_CFG_T1_LSB+5:`RLAR_CFG_T1_LSB] : cmd_q[5:0];
			always @(posedge core_clk_i) begin
				if (srst_i)
					term_o[g] <= 1'b0;
				else
					term_o[g] <= term_fn(code, lost, restarting, st_q == ST_TRIP);
			end
		end
	endgenerate
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			speed_cmd_o <= 16'h0;
			search_o <= 1'b0;
			fault_contact_o <= 1'b0;
			irq_stat_q <= 3'h0;
		end else begin
			if (st_q != ST_RUN || !run_q)
				speed_cmd_o <= 16'h0;
			else if (lost && act)
				speed_cmd_o <= red_spd;
			else
				speed_cmd_o <= ref_i;
			search_o <= (st_q == ST_RST);
			fault_contact_o <= (st_q == ST_TRIP) ||
				(restarting && cfg_q[`RLAR_CFG_FCS_BIT]);
			// set wins over clear
			irq_stat_q <= ev | (irq_stat_q &
				~((wr && paddr_i == `RLAR_IRQ_CLR_OFF) ? pwdata_i[2:0] : 3'h0));
		end
	end
	assign irq_o = |(irq_stat_q & irq_en_q);
endmodule

// ### rlar_regs.vh
`ifndef RLAR_REGS_VH
`define RLAR_REGS_VH
// apb register byte offsets
`define RLAR_CFG_OFF 12'h000
`define RLAR_REF_OFF 12'h004
`define RLAR_FLT_OFF 12'h008
`define RLAR_STAT_OFF 12'h00c
`define RLAR_IRQ_STAT_OFF 12'h010
`define RLAR_IRQ_CLR_OFF 12'h014
`define RLAR_IRQ_EN_OFF 12'h018
`define RLAR_CMD_OFF 12'h01c
// cfg fields
`define RLAR_CFG_ACT_BIT 0
`define RLAR_CFG_FCS_BIT 1
`define RLAR_CFG_PLR_LSB 2
`define RLAR_CFG_LIM_LSB 4
`define RLAR_CFG_RATIO_LSB 8
`define RLAR_CFG_T0_LSB 20
`define RLAR_CFG_T1_LSB 26
// reset values and limits
`define RLAR_RATIO_RST 10'h320
`define RLAR_RATIO_MAX 10'h3e8
`define RLAR_LIM_RST 4'h0
`define RLAR_LIM_MAX 4'ha
// terminal function codes
`define RLAR_FN_REF_LOST 6'h0c
`define RLAR_FN_RESTART 6'h1e
`define RLAR_FN_FAULT 6'h0e
// timing
`define RLAR_CLK_MHZ 250
`define RLAR_WIN_MS 400
`define RLAR_OK_MIN 10
`define RLAR_WIN_CYC (`RLAR_WIN_MS * 1000 * `RLAR_CLK_MHZ)
// forty-bit arithmetic: the product overflows a plain 32-bit integer
`define RLAR_OK_CYC (`RLAR_OK_MIN * 40'd60 * 40'd1000000 * `RLAR_CLK_MHZ)
`define RLAR_DIAG_CYC 8
// fault vector bits
`define RLAR_F_UV 4
`define RLAR_FLT_W 16
`define RLAR_ELIG_MASK 16'h3fff
`endif

// ### rlar_ref_mon.v
`include "rlar_regs.vh"
// watches the reference and flags a collapse of 90% or more within the window
module rlar_ref_mon #(
	parameter [31:0] WIN_CYC = `RLAR_WIN_CYC
) (
	input wire core_clk_i, // system clock
	input wire srst_i, // sync reset
	input wire [15:0] ref_i, // sampled reference
	input wire run_i, // drive running
	output reg lost_o // loss detected (level)
);
	reg [31:0] tmr_q;
	reg [15:0] base_q;
	// base is re-captured each window unless a loss is flagged; a drop to a tenth of it inside the window is a loss
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			tmr_q <= 32'h0;
			base_q <= 16'h0;
			lost_o <= 1'b0;
		end else if (!run_i) begin
			tmr_q <= 32'h0;
			base_q <= ref_i;
			lost_o <= 1'b0;
		end else begin
			if (!lost_o && base_q != 16'h0 && ({4'h0, ref_i} * 20'd10) <= {4'h0, base_q})
				lost_o <= 1'b1;
			else if (lost_o && ({4'h0, ref_i} * 20'd10) > {4'h0, base_q})
				lost_o <= 1'b0; // reference recovered
			if (tmr_q >= WIN_CYC - 32'h1) begin
				tmr_q <= 32'h0;
				if (!lost_o)
					base_q <= ref_i;
			end else begin
				tmr_q <= tmr_q + 32'h1;
			end
		end
	end
endmodule

// ### rlar_properties.sv
module rlar_checker (
	input wire logic core_clk_i, srst_i, psel_i, penable_i, pwrite_i, // clock, reset, apb
	input wire logic [11:0] paddr_i, // apb address
	input wire logic [31:0] pwdata_i, prdata_o, // apb data
	input wire logic pready_o, pslverr_o, search_o, fault_contact_o, irq_o, diag_err_i, // flags
	input wire logic [15:0] fault_i, speed_cmd_o, // faults, speed
	input wire logic [2:0] term_o // contacts
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	// bus phases
	sequence acc_s;
		psel_i && penable_i;
	endsequence
	sequence bad_s;
		acc_s ##0 paddr_i >= 12'h020;
	endsequence
	// a held fault that may never lead to a restart
	sequence odd_s;
		fault_i[15:14] != 2'h0;
	endsequence
	ready_high_a: assert property (pready_o) else $error("ready low");
	unmapped_err_a: assert property (bad_s |-> pslverr_o) else $error("no slave error");
	unmapped_zero_a: assert property (bad_s ##0 !pwrite_i |-> prdata_o == 32'h0)
		else $error("unmapped read not zero");
	search_pulse_a: assert property (search_o |=> !search_o) else $error("search too long");
	irq_mask_a: assert property (acc_s ##0 pwrite_i && paddr_i == 12'h018 &&
		pwdata_i[2:0] == 3'h0 |=> !irq_o) else $error("masked irq high");
	inelig_trip_a: assert property (odd_s [*8] |-> !search_o) else $error("restart on bad fault");
	diag_block_a: assert property (diag_err_i [*8] |-> !search_o) else $error("restart on diag");
	// reset itself is the antecedent, so the default disable is lifted
	reset_clear_a: assert property (disable iff (1'b0) srst_i |=> speed_cmd_o == 16'h0 &&
		term_o == 3'h0 && !search_o && !fault_contact_o && !irq_o) else $error("reset outputs");
endmodule
bind rlar_top rlar_checker u_chk (.core_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .search_o, .fault_contact_o, .irq_o, .diag_err_i,
	.fault_i, .speed_cmd_o, .term_o);

// ### rlar_ctl_model.sv
// controller: on a shown trip, confirms it and pulses error reset
module rlar_ctl_model (
	input wire logic core_clk_i, // clock
	input wire logic srst_i, // sync reset
	input wire logic arm_i, // allowed to confirm
	input wire logic trip_i, // fault contact seen
	output logic err_reset_o // error reset pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_q;
	// pulse long enough to pass the pin synchroniser
	always @(posedge core_clk_i) begin
		if (srst_i)
			cnt_q <= 3'h0;
		else if (cnt_q != 3'h0)
			cnt_q <= cnt_q - 3'h1;
		else if (arm_i && trip_i)
			cnt_q <= 3'h6;
	end
	assign err_reset_o = cnt_q != 3'h0;
endmodule

// ### rlar_top_tb.sv
module rlar_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, run_i = 1;
	logic diag_err_i = 0, arm = 0, pready_o, pslverr_o, search_o, fault_contact_o, irq_o, err_reset_i;
	logic [11:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, q;
	logic [15:0] ref_i = 16'h1000, fault_i = 0, speed_cmd_o, r;
	logic [2:0] term_o;
	int fails = 0, tests_run = 0, seed = 71065, n;
	always #2 core_clk_i = ~core_clk_i;
	// short windows keep the run brief
	rlar_top #(.WIN_CYC(32'd200), .OK_CYC(40'd500), .DIAG_CYC(8'd8)) u_dut (.core_clk_i, .srst_i,
		.psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.run_i, .ref_i, .fault_i, .diag_err_i, .err_reset_i, .speed_cmd_o, .search_o, .term_o,
		.fault_contact_o, .irq_o);
	rlar_ctl_model u_ctl (.core_clk_i, .srst_i, .arm_i(arm), .trip_i(fault_contact_o),
		.err_reset_o(err_reset_i));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	// entered just after an edge; holds the request until pready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i) penable_i <= 1;
		do @(posedge core_clk_i); while (pready_o !== 1'b1);
		q = prdata_o;
		psel_i <= 0;
		penable_i <= 0;
		@(posedge core_clk_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		chk(q, e);
	endtask
	// random restartable fault, undervoltage left out
	function automatic logic [15:0] elig();
		int b;
		b = $unsigned($random(seed)) % 14;
		return (b == 4) ? 16'h1 : 16'h1 << b;
	endfunction
	task automatic hit(input logic [15:0] b, input logic e);
		logic s, t;
		s = 0;
		t = 0;
		fault_i <= b;
		repeat (4) @(posedge core_clk_i);
		fault_i <= 0;
		repeat (40) @(posedge core_clk_i) begin
			s |= search_o;
			t |= term_o[1];
		end
		chk(s, e);
		if (e)
			chk(t, 1'b1);
	endtask
	task automatic clr();
		arm <= 1;
		repeat (20) @(posedge core_clk_i);
		arm <= 0;
		@(posedge core_clk_i);
		rd(12'h00c, 32'h0);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// hang guard, well above the expected 1500 or so cycles
	initial begin
		repeat (30000) @(posedge core_clk_i);
		fails++;
		close_out();
	end
	// main sequence
	initial begin
		repeat (5) @(posedge core_clk_i);
		srst_i <= 0;
		@(posedge core_clk_i);
		rd(12'h000, 32'h78c3_2000);
		rd(12'h00c, 32'h0);
		rd(12'h020, 32'h0);
		apb(1, 12'h018, 32'h7);
		apb(1, 12'h000, 32'h78c3_2022);
		hit(elig(), 1);
		rd(12'h00c, 32'h100);
		hit(16'h0010, 0);
		rd(12'h00c, 32'h130);
		chk(fault_contact_o, 1);
		rd(12'h010, 32'h6);
		chk(irq_o, 1);
		clr();
		apb(1, 12'h000, 32'h78c3_2026);
		hit(16'h0010, 1);
		hit(elig(), 1);
		hit(elig(), 0);
		rd(12'h00c, 32'h230);
		clr();
		diag_err_i <= 1;
		hit(elig(), 0);
		diag_err_i <= 0;
		clr();
		hit(16'h4000, 0);
		clr();
		hit(elig(), 1);
		repeat (560) @(posedge core_clk_i);
		rd(12'h00c, 32'h0);
		apb(1, 12'h018, 32'h0);
		chk(irq_o, 0);
		apb(1, 12'h014, 32'h7);
		rd(12'h010, 32'h0);
		// reference collapse with continue-on-loss at default ratio
		apb(1, 12'h000, 32'h78c3_2001);
		r = 16'd1000 + 16'($unsigned($random(seed)) % 15000);
		ref_i <= r;
		repeat (450) @(posedge core_clk_i);
		ref_i <= r / 20;
		for (n = 0; n < 450 && term_o[0] !== 1'b1; n++) @(posedge core_clk_i);
		repeat (4) @(posedge core_clk_i);
		chk({31'h0, term_o[0]}, 32'h1);
		chk({16'h0, speed_cmd_o}, (32'(r) * 800) / 1000);
		close_out();
	end
endmodule
